// ==== rtl/swp_status_protect.v ====
module swp_status_protect #(
    parameter ADDR_W = 24,
    parameter BLK_BASE = 2
) (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire writeProtectN,
    output reg memProgramStb_q,
    output reg memEraseStb_q,
    output reg [ADDR_W-1:0] memAddr_q,
    output reg statusWriteOk_q
);

`include "swp_map.vh"

// ============================================================
// Protection lookup
// Log2 of the protected span for a range code; 0 means nothing, and a
// result at or above ADDR_W means the whole array. Block mode starts at
// 64KB shifted by BLK_BASE so the table can follow any array size.
function integer spanLg;
    input [2:0] range;
    input smallUnit;
    integer lg;
    begin
        lg = 0;
        if (range != 3'h0) begin
            if (smallUnit) begin
                lg = `SWP_SECTOR_LG + range - 1;
                // Sector spans stop at 32KB; larger codes repeat it.
                if (lg > `SWP_SECTOR_MAX_LG) begin
                    lg = `SWP_SECTOR_MAX_LG;
                end
            // Code 7 in block mode always covers the whole array.
            end else if (range == 3'h7) begin
                lg = ADDR_W;
            end else begin
                lg = `SWP_BLOCK_LG + BLK_BASE + range - 1;
            end
        end
        spanLg = lg;
    end
endfunction

// True when the address may not be programmed or erased.
// Only one end of the array is ever in the base region.
function isReadOnly;
    input [ADDR_W-1:0] addr;
    input [2:0] range;
    input bottomSel;
    input smallUnit;
    input invert;
    integer lg;
    reg [ADDR_W-1:0] upper;
    reg [ADDR_W-1:0] ones;
    reg hit;
    begin
        lg = spanLg(range, smallUnit);
        ones = {ADDR_W{1'b1}};
        hit = 1'b0;
        // Code 0 protects nothing, so only the invert bit can lock.
        if (range == 3'h0) begin
            hit = 1'b0;
        end else if (lg >= ADDR_W) begin
            hit = 1'b1;
        end else begin
            // Keep the bits above the span; each span sits at one end.
            upper = addr >> lg;
            if (bottomSel) begin
                hit = (upper == {ADDR_W{1'b0}});
            end else begin
                hit = (upper == (ones >> lg));
            end
        end
        isReadOnly = hit ^ invert;
    end
endfunction

// ============================================================
// State
// Stored status registers; all three read back over the bus.
reg [7:0] status1_q;
reg [7:0] status1_d;
reg [7:0] status2_q;
reg [7:0] status2_d;
reg [7:0] status3_q;
reg [7:0] status3_d;
// Target address and the outcome of the last instruction.
reg [ADDR_W-1:0] addr_q;
reg [ADDR_W-1:0] addr_d;
reg accepted_q;
reg accepted_d;
reg rejected_q;
reg rejected_d;
// Next values of the registered outputs.
reg progStb_d;
reg eraseStb_d;
reg [ADDR_W-1:0] memAddr_d;
reg [31:0] rdData_d;
reg ack_d;
reg wrOk_d;

// A request is taken once: the pending ack masks it, so the edge after the one
// that raises ack cannot take the same write a second time.
wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire busWr = busReq & wb_we_i;
// Named views of the status fields used by the gating logic.
wire writeLatch = status1_q[`SWP_S1_WRITE_LATCH];
wire guard = status1_q[`SWP_S1_STATUS_GUARD];
wire lockdown = status2_q[`SWP_S2_STATUS_LOCKDOWN];
wire quadMode = status3_q[`SWP_S3_QUAD_MODE];
// Range code gathered from its three status positions.
wire [2:0] range = {status1_q[`SWP_S1_RANGE_HI],
    status1_q[`SWP_S1_RANGE_MID], status1_q[`SWP_S1_RANGE_LO]};
// The command code sits in byte lane 0, so that lane must be enabled.
wire [2:0] cmdCode = wb_dat_i[2:0];
wire cmdWr = busWr & wb_sel_i[0] & (wb_adr_i == `SWP_OFS_CMD);

// The pin only matters in standard or dual mode; quad mode reuses it as
// a data line, so the guard falls back to the software path there.
// guard gating
wire statusWriteOk = writeLatch & ~lockdown &
    (~guard | quadMode | writeProtectN);

// Target address for a program or erase is the stored address register.
// The check uses the bits as stored now; a status write lands one edge
// later, before any following command can be taken.
// read-only check
wire targetLocked = isReadOnly(addr_q, range,
    status1_q[`SWP_S1_BOTTOM_SELECT], status1_q[`SWP_S1_SMALL_UNIT],
    status2_q[`SWP_S2_INVERT_PROTECT]);

// ============================================================
// Instruction and bus write handling
always @* begin
    status1_d = status1_q;
    status2_d = status2_q;
    status3_d = status3_q;
    addr_d = addr_q;
    accepted_d = accepted_q;
    rejected_d = rejected_q;
    progStb_d = 1'b0;
    eraseStb_d = 1'b0;
    memAddr_d = memAddr_q;
    // The address register is a plain write and starts nothing.
    if (busWr && wb_adr_i == `SWP_OFS_ADDR) begin
        addr_d = wb_dat_i[ADDR_W-1:0];
    end
    // Each command is decoded on the edge that takes its bus write.
    if (cmdWr) begin
        case (cmdCode)
            `SWP_CMD_WRITE_ENABLE: begin
                status1_d[`SWP_S1_WRITE_LATCH] = 1'b1;
                accepted_d = 1'b1;
                rejected_d = 1'b0;
            end
            // Write-disable drops only the latch; protection stays.
            `SWP_CMD_WRITE_DISABLE: begin
                status1_d[`SWP_S1_WRITE_LATCH] = 1'b0;
                accepted_d = 1'b1;
                rejected_d = 1'b0;
            end
            `SWP_CMD_WRITE_STATUS: begin
                if (statusWriteOk) begin
                    status1_d = wb_dat_i[15:8];
                    status2_d = wb_dat_i[23:16];
                    status3_d = wb_dat_i[31:24];
                    // No timing is modelled, so busy is never stored.
                    status1_d[`SWP_S1_BUSY] = 1'b0;
                    // Lockdown can be set here but never cleared by it.
                    status2_d[`SWP_S2_STATUS_LOCKDOWN] =
                        wb_dat_i[16 + `SWP_S2_STATUS_LOCKDOWN] | lockdown;
                end
                accepted_d = statusWriteOk;
                rejected_d = ~statusWriteOk;
                status1_d[`SWP_S1_WRITE_LATCH] = 1'b0;
            end
            `SWP_CMD_PROGRAM, `SWP_CMD_ERASE: begin
                if (writeLatch && !targetLocked) begin
                    progStb_d = (cmdCode == `SWP_CMD_PROGRAM);
                    eraseStb_d = (cmdCode == `SWP_CMD_ERASE);
                    memAddr_d = addr_q;
                    accepted_d = 1'b1;
                    rejected_d = 1'b0;
                end else begin
                    accepted_d = 1'b0;
                    rejected_d = 1'b1;
                end
                // The latch drops whether or not the command went through.
                status1_d[`SWP_S1_WRITE_LATCH] = 1'b0;
            end
            // Unknown codes leave every flag as it was.
            default: begin
                accepted_d = accepted_q;
                rejected_d = rejected_q;
            end
        endcase
    end
end

// ============================================================
// Bus read data and acknowledge
// status readback
always @* begin
    rdData_d = 32'h0000_0000;
    // Every taken request is answered on the next edge, mapped or not.
    ack_d = busReq;
    // Write permission is exported one cycle late, like every output.
    wrOk_d = statusWriteOk;
    // Unmapped offsets read as zero, so software probing is harmless.
    case (wb_adr_i)
        `SWP_OFS_STATUS1: rdData_d = {24'h00_0000, status1_q};
        `SWP_OFS_STATUS2: rdData_d = {24'h00_0000, status2_q};
        `SWP_OFS_STATUS3: rdData_d = {24'h00_0000, status3_q};
        `SWP_OFS_ADDR: rdData_d = {{(32-ADDR_W){1'b0}}, addr_q};
        `SWP_OFS_RESULT: rdData_d = {29'h0000_0000, statusWriteOk,
            rejected_q, accepted_q};
        default: rdData_d = 32'h0000_0000;
    endcase
end

// ============================================================
// Registers. Reset stands for a power-up: it restores every stored bit,
// which is also the only way out of lockdown.
// With ce low nothing moves, ack included, so a master just waits.
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        status1_q <= `SWP_S1_RESET;
        status2_q <= `SWP_S2_RESET;
        status3_q <= `SWP_S3_RESET;
        addr_q <= {ADDR_W{1'b0}};
        accepted_q <= 1'b0;
        rejected_q <= 1'b0;
        // Outputs fall with reset so the memory never sees a stray strobe.
        memProgramStb_q <= 1'b0;
        memEraseStb_q <= 1'b0;
        memAddr_q <= {ADDR_W{1'b0}};
        statusWriteOk_q <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
        wb_ack_o <= 1'b0;
    end else if (ce) begin
        status1_q <= status1_d;
        status2_q <= status2_d;
        status3_q <= status3_d;
        addr_q <= addr_d;
        accepted_q <= accepted_d;
        rejected_q <= rejected_d;
        memProgramStb_q <= progStb_d;
        memEraseStb_q <= eraseStb_d;
        memAddr_q <= memAddr_d;
        statusWriteOk_q <= wrOk_d;
        wb_dat_o <= rdData_d;
        wb_ack_o <= ack_d;
    end
end

endmodule

// ==== rtl/swp_map.vh ====
`ifndef SWP_MAP_VH
`define SWP_MAP_VH

// ============================================================
// Register byte offsets on the bus.
`define SWP_OFS_STATUS1 8'h00
`define SWP_OFS_STATUS2 8'h04
`define SWP_OFS_STATUS3 8'h08
`define SWP_OFS_CMD 8'h0c
`define SWP_OFS_ADDR 8'h10
`define SWP_OFS_RESULT 8'h14

// ============================================================
// Status register 1 field positions.
`define SWP_S1_BUSY 0
`define SWP_S1_WRITE_LATCH 1
`define SWP_S1_RANGE_LO 2
`define SWP_S1_RANGE_MID 3
`define SWP_S1_RANGE_HI 4
`define SWP_S1_BOTTOM_SELECT 5
`define SWP_S1_SMALL_UNIT 6
`define SWP_S1_STATUS_GUARD 7

// Status register 2 field positions (bit 6 is combined position 14).
`define SWP_S2_STATUS_LOCKDOWN 0
`define SWP_S2_INVERT_PROTECT 6

// Status register 3: link mode flag.
`define SWP_S3_QUAD_MODE 0

// ============================================================
// Reset values of the status registers.
`define SWP_S1_RESET 8'h00
`define SWP_S2_RESET 8'h00
`define SWP_S3_RESET 8'h00

// ============================================================
// Instruction codes written to the command register.
`define SWP_CMD_NONE 3'h0
`define SWP_CMD_WRITE_ENABLE 3'h1
`define SWP_CMD_WRITE_DISABLE 3'h2
`define SWP_CMD_WRITE_STATUS 3'h3
`define SWP_CMD_PROGRAM 3'h4
`define SWP_CMD_ERASE 3'h5

// ============================================================
// Protection unit sizes as address bit counts.
`define SWP_SECTOR_LG 12
`define SWP_BLOCK_LG 16
`define SWP_SECTOR_MAX_LG 15

`endif

// ==== verif/swp_status_protect_properties.sv ====
module swp_status_protect_checker #(
    parameter ADDR_W = 24
) (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire wb_ack_o,
    input wire memProgramStb_q,
    input wire memEraseStb_q,
    input wire [ADDR_W-1:0] memAddr_q
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // Bus and strobe timing
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    AST_ACK_LATENCY: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
        else $error("ack did not follow a request");
    AST_ACK_ONE: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_PROG_PULSE: assert property (
        memProgramStb_q && ce |=> !memProgramStb_q)
        else $error("program strobe too long");
    AST_ERASE_PULSE: assert property (
        memEraseStb_q && ce |=> !memEraseStb_q)
        else $error("erase strobe too long");
    AST_STB_IN_ACK: assert property (
        memProgramStb_q || memEraseStb_q |-> wb_ack_o)
        else $error("strobe outside ack cycle");
    AST_ONE_KIND: assert property (!(memProgramStb_q && memEraseStb_q))
        else $error("program and erase together");
    AST_ADDR_HELD: assert property (
        $changed(memAddr_q) |-> memProgramStb_q || memEraseStb_q)
        else $error("address moved without strobe");
    AST_STB_CAUSE: assert property (
        $rose(memProgramStb_q) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
        else $error("program strobe without bus write");
endmodule

bind swp_status_protect swp_status_protect_checker #(.ADDR_W(ADDR_W))
    swp_status_protect_checker_i (.clk(clk), .nrst(nrst), .ce(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .memProgramStb_q(memProgramStb_q),
    .memEraseStb_q(memEraseStb_q), .memAddr_q(memAddr_q));

// ==== verif/swp_host_model.sv ====
module swp_host_model (
    input wire logic clk,
    input wire logic holdLock,
    output logic writeProtectN
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // Protect pin driver
    // Starts high so status writes are not blocked before the bench decides.
    initial writeProtectN = 1'b1;
    always @(posedge clk) begin
        writeProtectN <= !holdLock;
    end
endmodule

// ==== verif/tb_swp_status_protect.sv ====
`include "swp_map.vh"
module tb_swp_status_protect;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, wbCyc = 1'b0, wbStb = 1'b0;
    logic wbWe = 1'b0, wbAck, holdLock = 1'b0, wpN, pStb, eStb, okQ;
    logic pSeen, eSeen;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDatI = 32'h0, wbDatO, rdat;
    logic [23:0] memAddr;
    int mismatches = 0, checkCount = 0;
    // ====================
    // Instances
    swp_status_protect #(.ADDR_W(24), .BLK_BASE(2)) swp_status_protect_i (
        .clk(clk), .nrst(nrst), .ce(ce), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .writeProtectN(wpN),
        .memProgramStb_q(pStb), .memEraseStb_q(eStb), .memAddr_q(memAddr),
        .statusWriteOk_q(okQ));
    swp_host_model swp_host_model_i (.clk(clk), .holdLock(holdLock),
        .writeProtectN(wpN));
    // Free running 250 MHz clock.
    always #2 clk = ~clk;
    // ====================
    // Bus tasks
    // One classic cycle; outputs are read before the edge's own updates land.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDatI <= d;
        // Wait as long as it takes; only the watchdog ends a hang.
        do begin
            @(posedge clk);
        end while (wbAck !== 1'b1);
        rdat = wbDatO;
        pSeen = pStb;
        eSeen = eStb;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checkCount++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // Write-enable first, since the latch gates every status write.
    task automatic ws(input logic [7:0] s1, s2, s3);
        bus(1'b1, `SWP_OFS_CMD, 32'h1);
        bus(1'b1, `SWP_OFS_CMD, {s3, s2, s1, 8'h03});
    endtask
    task automatic pe(input logic [2:0] c, input logic [23:0] a,
                      input logic ok);
        bus(1'b1, `SWP_OFS_ADDR, {8'h00, a});
        bus(1'b1, `SWP_OFS_CMD, 32'h1);
        bus(1'b1, `SWP_OFS_CMD, {29'h0, c});
        chk(c == `SWP_CMD_PROGRAM ? pSeen : eSeen, ok);
        if (ok) chk({8'h00, memAddr}, {8'h00, a});
        rd(`SWP_OFS_RESULT, ok ? 32'h1 : 32'h2);
    endtask
    task automatic results;
        $display("checks=%0d mismatches=%0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ====================
    // Watchdog: the sequence needs under two hundred cycles.
    initial begin
        #40000;
        mismatches++;
        results();
    end
    // ====================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(`SWP_OFS_STATUS1, 32'h0);
        rd(`SWP_OFS_STATUS2, 32'h0);
        bus(1'b1, `SWP_OFS_CMD, {16'h0, 8'h20, 8'h03});
        rd(`SWP_OFS_STATUS1, 32'h0);
        bus(1'b1, `SWP_OFS_CMD, 32'h1);
        rd(`SWP_OFS_STATUS1, 32'h2);
        chk({31'h0, okQ}, 32'h1);
        holdLock <= 1'b1;
        ws(8'h84, 8'h00, 8'h00);
        rd(`SWP_OFS_STATUS1, 32'h84);
        ws(8'h00, 8'h00, 8'h00);
        rd(`SWP_OFS_STATUS1, 32'h84);
        bus(1'b1, `SWP_OFS_CMD, 32'h1);
        rd(`SWP_OFS_RESULT, 32'h1);
        chk({31'h0, okQ}, 32'h0);
        pe(`SWP_CMD_PROGRAM, 24'hfff000, 1'b0);
        pe(`SWP_CMD_ERASE, 24'h000000, 1'b1);
        holdLock <= 1'b0;
        ws(8'ha4, 8'h00, 8'h00);
        rd(`SWP_OFS_STATUS1, 32'ha4);
        pe(`SWP_CMD_PROGRAM, 24'h000000, 1'b0);
        pe(`SWP_CMD_PROGRAM, 24'hfff000, 1'b1);
        ws(8'he4, 8'h00, 8'h01);
        rd(`SWP_OFS_STATUS3, 32'h1);
        holdLock <= 1'b1;
        ws(8'he4, 8'h40, 8'h01);
        rd(`SWP_OFS_STATUS2, 32'h40);
        pe(`SWP_CMD_ERASE, 24'h001000, 1'b0);
        pe(`SWP_CMD_ERASE, 24'h000000, 1'b1);
        ws(8'he4, 8'h41, 8'h01);
        ws(8'h00, 8'h40, 8'h01);
        rd(`SWP_OFS_STATUS1, 32'he4);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(`SWP_OFS_STATUS2, 32'h0);
        results();
    end
endmodule
